// >>> testbench/rdc_i2c_host.sv
// I2C host model on a pulled-up open-drain SDA wire.
// Assumes one transfer at a time, paced by sys_clk.
`timescale 1ns/1ps
module rdc_i2c_host
(
  // Clock
  input  wire logic sys_clk,
  // Bus wires
  input  wire logic sdaOeN_q,
  output logic      sclIn,
  output logic      sdaIn
);
  logic sdaRel = 1'b1;

  // Wired-AND of both parties; released line floats high
  assign sdaIn = sdaRel & sdaOeN_q;
  // Idle bus: clock stands high
  initial sclIn = 1'b1;

  // One SCL phase, seen by several samples
  task automatic half();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : half

  // Start or repeated start
  task automatic start();
    sdaRel = 1'b1;
    half();
    sclIn = 1'b1;
    half();
    sdaRel = 1'b0;
    half();
    sclIn = 1'b0;
  endtask : start

  // Stop, leaving the bus idle
  task automatic stop();
    sdaRel = 1'b0;
    half();
    sclIn = 1'b1;
    half();
    sdaRel = 1'b1;
    half();
  endtask : stop

  // Eight bits MSB first, then the acknowledge slot
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic [8:0] sh;
    sh = {b, 1'b1};
    for (int i = 0; i < 9; i++)
    begin
      sdaRel = sh[8-i];
      half();
      sclIn = 1'b1;
      half();
      ack = ~sdaIn;
      sclIn = 1'b0;
    end
  endtask : sendByte

  // Eight bits from the slave MSB first, then the host's acknowledge (1 ends the read)
  task automatic recvByte(input logic nack, output logic [7:0] b);
    for (int i = 0; i < 9; i++)
    begin
      sdaRel = (i < 8) ? 1'b1 : nack;
      half();
      sclIn = 1'b1;
      half();
      if (i < 8)
        b = {b[6:0], sdaIn};
      sclIn = 1'b0;
    end
  endtask : recvByte

endmodule : rdc_i2c_host

// >>> testbench/rdc_mode_ctrl_chk.sv
// Assertions on the configuration control top ports.
// Assumes it is bound into every rdc_mode_ctrl instance.
`timescale 1ns/1ps
module rdc_mode_ctrl_chk
#(
  parameter int NUM_CH = 4
)
(
  // Clock and reset
  sys_clk, rst_b,
  // Pins
  cable_absent, host_config_select, boost_strap, swing_strap,
  gain_strap_lo, gain_hi_or_reg_default_n,
  // Outputs watched
  sdaOeN_q, lowPower_q, hostMode_q, chanCfg
);
  import rdc_pkg::*;
  input wire logic                   sys_clk;
  input wire logic                   rst_b;
  input wire logic                   cable_absent;
  input wire logic                   host_config_select;
  input wire logic [3:0]             boost_strap;
  input wire logic [1:0]             swing_strap;
  input wire logic                   gain_strap_lo;
  input wire logic                   gain_hi_or_reg_default_n;
  input wire logic                   sdaOeN_q;
  input wire logic                   lowPower_q;
  input wire logic                   hostMode_q;
  input wire rdc_pkg::rdc_chan_cfg_t chanCfg [NUM_CH];
  wire                               pinOn;
  wire                               regClr;

  // Pin mode with cable present, and register default request
  assign pinOn  = !host_config_select && !cable_absent;
  assign regClr = host_config_select && !gain_hi_or_reg_default_n;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Power state and mode
  a_cable_low_power: assert property (cable_absent[*2] |=> lowPower_q && chanCfg[0].powerDown)
    else $error("low power not entered");
  a_cable_normal: assert property (pinOn[*2] |=> !lowPower_q && !chanCfg[NUM_CH-1].powerDown)
    else $error("normal operation not entered");
  a_mode_follow: assert property (host_config_select[*2] |=> hostMode_q)
    else $error("register mode not entered");
  a_pin_idle: assert property ((!host_config_select)[*2] |=> !hostMode_q && sdaOeN_q)
    else $error("pin mode not idle");
  // Strap values reach the channels; gain decode and register default
  a_pin_boost: assert property (pinOn[*2] |=> chanCfg[0].boost == $past(boost_strap))
    else $error("boost strap not applied");
  a_pin_swing: assert property (pinOn[*2] |=> chanCfg[1].swing == $past(swing_strap))
    else $error("swing strap not applied");
  a_gain_low_bit: assert property (pinOn[*2] |=> chanCfg[2].gainCode[0] == $past(gain_strap_lo))
    else $error("gain bit 0 wrong");
  a_gain_high_bit: assert property (pinOn[*2] |=>
    chanCfg[NUM_CH-1].gainCode[1] == $past(gain_hi_or_reg_default_n))
    else $error("gain bit 1 wrong");
  a_gain_decode: assert property ($past(rst_b) |->
    int'($signed(chanCfg[1].gainTenthDb)) == 20 * int'(chanCfg[1].gainCode) - 35)
    else $error("gain decode wrong");
  a_reg_default: assert property (regClr[*3] |=> chanCfg[0].boost == 4'h0 && chanCfg[0].gainCode == 2'h0)
    else $error("registers not defaulted");

endmodule : rdc_mode_ctrl_chk

bind rdc_mode_ctrl rdc_mode_ctrl_chk #(.NUM_CH(NUM_CH)) i_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .cable_absent(cable_absent), .host_config_select(host_config_select),
  .boost_strap(boost_strap), .swing_strap(swing_strap), .gain_strap_lo(gain_strap_lo),
  .gain_hi_or_reg_default_n(gain_hi_or_reg_default_n), .sdaOeN_q(sdaOeN_q),
  .lowPower_q(lowPower_q), .hostMode_q(hostMode_q), .chanCfg(chanCfg));

// >>> testbench/test_rdc_mode_ctrl.sv
// Self-checking bench for the redriver configuration control.
// Assumes the I2C host model and the bound checker sit beside the design.
`timescale 1ns/1ps
`define CHK(got, exp) begin cmpCount++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module test_rdc_mode_ctrl;
  import rdc_pkg::*;
  logic          sys_clk = 1'b0;
  logic          rst_b = 1'b0;
  logic          cable_absent = 1'b0;
  logic          host_config_select = 1'b0;
  logic [3:0]    boost_strap = 4'h0;
  logic [1:0]    swing_strap = 2'h0;
  logic          gain_strap_lo = 1'b0;
  logic          gain_hi_or_reg_default_n = 1'b1;
  logic          sclIn, sdaIn, sdaOut_q, sdaOeN_q, lowPower_q, hostMode_q, ack;
  rdc_chan_cfg_t chanCfg [NUM_CHAN];
  rdc_chan_cfg_t expd;
  logic [31:0]   rng = 32'h0000_003B;
  logic [31:0]   r;
  logic [7:0]    dat [NUM_CHAN];
  logic [7:0]    rd0, rd1;
  int            miscompares = 0;
  int            cmpCount = 0;

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  rdc_mode_ctrl i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .cable_absent(cable_absent),
    .host_config_select(host_config_select), .boost_strap(boost_strap),
    .swing_strap(swing_strap), .gain_strap_lo(gain_strap_lo),
    .gain_hi_or_reg_default_n(gain_hi_or_reg_default_n), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut_q(sdaOut_q), .sdaOeN_q(sdaOeN_q), .lowPower_q(lowPower_q),
    .hostMode_q(hostMode_q), .chanCfg(chanCfg));
  rdc_i2c_host i_host (.sys_clk(sys_clk), .sdaOeN_q(sdaOeN_q), .sclIn(sclIn), .sdaIn(sdaIn));

  // Xorshift source of stimulus
  function automatic logic [31:0] nextRnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : nextRnd

  // Channel settings expected from their sources
  function automatic rdc_chan_cfg_t expCfg(logic [3:0] b, logic [1:0] s, logic [1:0] g, logic p);
    return '{b, s, g, 8'(20 * int'(g) - 35), p};
  endfunction : expCfg

  // Wait edges, then step just past the last
  task automatic step(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  // Addressed write of one register through the host model
  task automatic regWrite(logic [7:0] ptr, logic [7:0] d);
    logic [7:0] seq [3];
    seq = '{{3'h7, boost_strap, 1'b0}, ptr, d};
    i_host.start();
    foreach (seq[k])
    begin
      i_host.sendByte(seq[k], ack);
      `CHK(ack, 1'b1)
    end
    i_host.stop();
  endtask : regWrite

  // Verdict and end of run
  task automatic report_and_stop();
    if (miscompares == 0 && cmpCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // Hang guard
  initial
  begin
    repeat (10000) @(posedge sys_clk);
    miscompares++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    step(6);
    rst_b = 1'b1;
    // Pin mode: random straps, all gain codes first
    for (int i = 0; i < 40; i++)
    begin
      r = nextRnd();
      if (i < 4)
        r[1:0] = 2'(i);
      {boost_strap, swing_strap, gain_hi_or_reg_default_n, gain_strap_lo} = r[7:0];
      cable_absent = r[9] && i > 3;
      step(3);
      expd = expCfg(boost_strap, swing_strap, {gain_hi_or_reg_default_n, gain_strap_lo}, 1'b0);
      for (int c = 0; c < NUM_CHAN; c++)
        if (cable_absent)
          `CHK(chanCfg[c].powerDown, 1'b1)
        else
          `CHK(chanCfg[c], expd)
    end
    // Register mode: wrong address refused, then per-channel writes
    host_config_select = 1'b1;
    cable_absent = 1'b0;
    gain_hi_or_reg_default_n = 1'b1;
    r = nextRnd();
    boost_strap = r[3:0];
    step(3);
    i_host.start();
    i_host.sendByte({3'h7, boost_strap ^ 4'h1, 1'b0}, ack);
    `CHK(ack, 1'b0)
    i_host.stop();
    `CHK(hostMode_q, 1'b1)
    `CHK(sdaOut_q, 1'b0)
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      r = nextRnd();
      dat[c] = r[7:0];
      regWrite(8'(3 + c), dat[c]);
    end
    swing_strap = ~swing_strap;
    gain_strap_lo = ~gain_strap_lo;
    step(3);
    for (int c = 0; c < NUM_CHAN; c++)
      `CHK(chanCfg[c], expCfg(dat[c][7:4], dat[c][1:0], dat[c][3:2], 1'b0))
    // Pointer-only write, repeated start, then read two channel bytes back
    i_host.start();
    i_host.sendByte({3'h7, boost_strap, 1'b0}, ack);
    i_host.sendByte(REG_CHAN0, ack);
    i_host.start();
    i_host.sendByte({3'h7, boost_strap, 1'b1}, ack);
    `CHK(ack, 1'b1)
    i_host.recvByte(1'b0, rd0);
    i_host.recvByte(1'b1, rd1);
    i_host.stop();
    `CHK(rd0, dat[0])
    `CHK(rd1, dat[1])
    r = nextRnd();
    regWrite(8'h02, {r[3:0], 4'h0});
    step(2);
    for (int c = 0; c < NUM_CHAN; c++)
      `CHK(chanCfg[c].powerDown, r[c])
    // Default request clears the bank
    gain_hi_or_reg_default_n = 1'b0;
    step(3);
    gain_hi_or_reg_default_n = 1'b1;
    step(2);
    for (int c = 0; c < NUM_CHAN; c++)
      `CHK(chanCfg[c], expCfg(4'h0, 2'h0, 2'h0, 1'b0))
    cable_absent = 1'b1;
    step(3);
    `CHK(lowPower_q, 1'b1)
    report_and_stop();
  end

endmodule : test_rdc_mode_ctrl

// >>> verilog/rdc_chan_mux.sv
// One channel's setting multiplexer with registered outputs.
// Assumes the parent supplies the mode, low-power state and register byte.
`timescale 1ns/1ps
module rdc_chan_mux
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  // Mode and power
  input  wire logic               hostMode,
  input  wire logic               lowPower,
  input  wire logic               regPowerDown,
  // Setting sources
  input  wire rdc_pkg::rdc_strap_t strap,
  input  wire logic [7:0]         regByte,
  // Channel controls
  output rdc_pkg::rdc_chan_cfg_t  cfg_q
);
  import rdc_pkg::*;

  rdc_chan_cfg_t cfg_d;

  // Select strap or register source
  always_comb
  begin
    cfg_d = '0;
    if (hostMode)
    begin
      cfg_d.boost    = regByte[FLD_BOOST_LSB +: 4];
      cfg_d.swing    = regByte[FLD_SWING_LSB +: 2];
      cfg_d.gainCode = regByte[FLD_GAIN_LSB +: 2];
    end
    else
    begin
      cfg_d.boost    = strap.boost;
      cfg_d.swing    = strap.swing;
      cfg_d.gainCode = {strap.gainHi, strap.gainLo};
    end
    cfg_d.gainTenthDb = rdc_gain_decode(cfg_d.gainCode);
    cfg_d.powerDown   = lowPower | (hostMode & regPowerDown);
  end

  // Output register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      cfg_q <= '0;
    else
      cfg_q <= cfg_d;
  end

endmodule : rdc_chan_mux

// >>> verilog/rdc_mode_ctrl.sv
// Top of the redriver configuration control: mode select, power state,
// I2C register bank with slave, and the four per-channel multiplexers.
// Assumes SCL and SDA are sampled on sys_clk, far faster than the I2C clock,
// and that the board resolves the open-drain SDA wire from sdaOeN.
`timescale 1ns/1ps
module rdc_mode_ctrl
#(
  parameter int NUM_CH = rdc_pkg::NUM_CHAN
)
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  // Mode and power pins
  input  wire logic                  cable_absent,
  input  wire logic                  host_config_select,
  // Strap pins
  input  wire logic [3:0]            boost_strap,
  input  wire logic [1:0]            swing_strap,
  input  wire logic                  gain_strap_lo,
  input  wire logic                  gain_hi_or_reg_default_n,
  // I2C pins
  input  wire logic                  sclIn,
  input  wire logic                  sdaIn,
  output logic                       sdaOut_q,
  output logic                       sdaOeN_q,
  // Status
  output logic                       lowPower_q,
  output logic                       hostMode_q,
  // Channel controls
  output rdc_pkg::rdc_chan_cfg_t     chanCfg [NUM_CH]
);
  import rdc_pkg::*;

  // Slave states
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_ADDR  = 7'b000_0010,
    ST_AACK  = 7'b000_0100,
    ST_WDATA = 7'b000_1000,
    ST_WACK  = 7'b001_0000,
    ST_RDATA = 7'b010_0000,
    ST_RACK  = 7'b100_0000
  } rdc_state_t;

  rdc_state_t  state_q;
  logic        sclPrev_q;
  logic        sdaPrev_q;
  logic [3:0]  bitCnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  ptr_q;
  logic        readMode_q;
  logic        ptrPhase_q;
  logic [7:0]  regs_q [NUM_REGS];
  logic        regWrEn;
  logic [7:0]  regWrData;
  logic [6:0]  slaveAddr;
  logic        regDefault;
  logic        sclRise;
  logic        sclFall;
  logic        startCond;
  logic        stopCond;
  rdc_strap_t  strap;
  logic [7:0]  rdByte;

  // Register read with reserved bytes reading zero
  function automatic logic [7:0] regRead(input logic [7:0] idx);
    if (idx >= REG_PWR_DOWN && idx < 8'(NUM_REGS))
      regRead = regs_q[idx[2:0]];
    else
      regRead = 8'h00;
  endfunction : regRead

  // Byte at the pointer, loaded when a read starts
  assign rdByte = regRead(ptr_q);

  // Strap grouping and slave address
  assign strap.boost  = boost_strap;
  assign strap.swing  = swing_strap;
  assign strap.gainLo = gain_strap_lo;
  assign strap.gainHi = gain_hi_or_reg_default_n;
  assign slaveAddr    = {I2C_ADDR_HI, boost_strap};

  // Register default request from the shared pin in I2C mode
  assign regDefault = host_config_select & ~gain_hi_or_reg_default_n;

  // Bus condition detection from the previous pin samples
  assign sclRise   = sclIn & ~sclPrev_q;
  assign sclFall   = ~sclIn & sclPrev_q;
  assign startCond = sclIn & sclPrev_q & sdaPrev_q & ~sdaIn;
  assign stopCond  = sclIn & sclPrev_q & ~sdaPrev_q & sdaIn;

  // Pin history
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end
    else
    begin
      sclPrev_q <= sclIn;
      sdaPrev_q <= sdaIn;
    end
  end

  // Mode and power status
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      lowPower_q <= 1'b1;
      hostMode_q <= 1'b0;
    end
    else
    begin
      lowPower_q <= cable_absent;
      hostMode_q <= host_config_select;
    end
  end

  // Write strobe when a data byte completes on the falling clock
  always_comb
  begin
    regWrEn   = 1'b0;
    regWrData = shift_q;
    if (state_q == ST_WDATA && sclFall && bitCnt_q == BITS_PER_BYTE && !ptrPhase_q)
      regWrEn = host_config_select & ~stopCond;
  end

  // Slave sequencing
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || !host_config_select)
    begin
      state_q    <= ST_IDLE;
      bitCnt_q   <= 4'h0;
      shift_q    <= 8'h00;
      readMode_q <= 1'b0;
      ptrPhase_q <= 1'b0;
      sdaOeN_q   <= 1'b1;
    end
    else if (startCond)
    begin
      state_q  <= ST_ADDR;
      bitCnt_q <= 4'h0;
      sdaOeN_q <= 1'b1;
    end
    else if (stopCond)
    begin
      state_q  <= ST_IDLE;
      sdaOeN_q <= 1'b1;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          sdaOeN_q <= 1'b1;
        end
        ST_ADDR, ST_WDATA:
        begin
          if (sclRise && bitCnt_q < BITS_PER_BYTE)
          begin
            shift_q  <= {shift_q[6:0], sdaIn};
            bitCnt_q <= bitCnt_q + 4'h1;
          end
          else if (sclFall && bitCnt_q == BITS_PER_BYTE)
          begin
            if (state_q == ST_WDATA)
            begin
              ptrPhase_q <= 1'b0;
              state_q    <= ST_WACK;
              sdaOeN_q   <= 1'b0;  // Acknowledge the data byte
            end
            else if (shift_q[7:1] == slaveAddr)
            begin
              readMode_q <= shift_q[0];
              state_q    <= ST_AACK;
              sdaOeN_q   <= 1'b0;  // Acknowledge own address
            end
            else
              state_q <= ST_IDLE;
          end
        end
        ST_AACK:
        begin
          if (sclFall)
          begin
            bitCnt_q <= 4'h0;
            if (readMode_q)
            begin
              shift_q  <= rdByte;
              sdaOeN_q <= rdByte[7];
              state_q  <= ST_RDATA;
            end
            else
            begin
              ptrPhase_q <= 1'b1;
              sdaOeN_q   <= 1'b1;
              state_q    <= ST_WDATA;
            end
          end
        end
        ST_WACK:
        begin
          if (sclFall)
          begin
            bitCnt_q <= 4'h0;
            sdaOeN_q <= 1'b1;
            state_q  <= ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (sclRise)
            bitCnt_q <= bitCnt_q + 4'h1;
          else if (sclFall)
          begin
            if (bitCnt_q == BITS_PER_BYTE)
            begin
              sdaOeN_q <= 1'b1;  // Release for the master's acknowledge
              state_q  <= ST_RACK;
            end
            else
              sdaOeN_q <= shift_q[3'(4'h7 - bitCnt_q)];
          end
        end
        ST_RACK:
        begin
          if (sclRise)
          begin
            bitCnt_q <= 4'h0;
            if (sdaIn)
              state_q <= ST_IDLE;  // Master ended the read
            else
            begin
              shift_q <= regRead(ptr_q);
              state_q <= ST_RDATA;
            end
          end
        end
        default:
        begin
          state_q  <= ST_IDLE;
          sdaOeN_q <= 1'b1;
        end
      endcase
    end
  end

  // Register pointer: loaded by the first written byte, stepped per data byte
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      ptr_q <= 8'h00;
    else if (state_q == ST_WDATA && sclFall && bitCnt_q == BITS_PER_BYTE)
      ptr_q <= ptrPhase_q ? shift_q : ptr_q + 8'h01;
    else if (state_q == ST_RDATA && sclFall && bitCnt_q == BITS_PER_BYTE)
      ptr_q <= ptr_q + 8'h01;
  end

  // Open-drain data only ever drives low
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      sdaOut_q <= 1'b0;
    else
      sdaOut_q <= 1'b0;
  end

  // Register bank; default request wins over a write
  generate
    for (genvar r = 0; r < NUM_REGS; r++)
    begin : g_reg
      always_ff @(posedge sys_clk)
      begin
        if (!rst_b || regDefault)
          regs_q[r] <= REG_RESET;
        else if (regWrEn && ptr_q == 8'(r) && ptr_q >= REG_PWR_DOWN)
          regs_q[r] <= regWrData;
      end
    end
  endgenerate

  // Per-channel setting multiplexers
  generate
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_chan
      rdc_chan_mux u_mux
      (
        .sys_clk      (sys_clk),
        .rst_b        (rst_b),
        .hostMode     (host_config_select),
        .lowPower     (cable_absent),
        .regPowerDown (regs_q[REG_PWR_DOWN[2:0]][FLD_PD_LSB + c]),
        .strap        (strap),
        .regByte      (regs_q[3'(REG_CHAN0[2:0] + 3'(c))]),
        .cfg_q        (chanCfg[c])
      );
    end
  endgenerate

endmodule : rdc_mode_ctrl

// >>> verilog/rdc_pkg.sv
// Constants, types and helpers for the redriver configuration control.
// Assumes one clock (sys_clk) and strap and I2C pins already synchronous to it.
// What this block does
// - Cable absent high forces low-power mode
// - Cable absent low enables normal operation
// - Select high: I2C slave, settings from registers
// - Select low: pin mode, settings from straps
// - Pin mode: boost strap drives every channel
// - I2C mode: boost straps form slave address bits
// - Pin mode: swing strap drives every channel
// - Pin mode: low gain strap is gain bit0
// - Pin mode: shared pin is gain bit1
// - I2C mode: shared pin low resets registers
// - Gain codes decode to -3.5/-1.5/0.5/2.5 dB
package rdc_pkg;

  // Channel count and I2C framing
  localparam int          NUM_CHAN      = 4;
  localparam int          NUM_REGS      = 7;
  localparam logic [2:0]  I2C_ADDR_HI   = 3'h7;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  // Register indices
  localparam logic [7:0]  REG_PWR_DOWN  = 8'h02;
  localparam logic [7:0]  REG_CHAN0     = 8'h03;

  // Field positions inside a channel byte and the power-down byte
  localparam int          FLD_BOOST_LSB = 4;
  localparam int          FLD_GAIN_LSB  = 2;
  localparam int          FLD_SWING_LSB = 0;
  localparam int          FLD_PD_LSB    = 4;

  // Register reset value
  localparam logic [7:0]  REG_RESET     = 8'h00;

  // Flat gain in tenths of a dB per code
  localparam logic signed [7:0] GAIN_CODE0 = -8'sd35;
  localparam logic signed [7:0] GAIN_CODE1 = -8'sd15;
  localparam logic signed [7:0] GAIN_CODE2 = 8'sd5;
  localparam logic signed [7:0] GAIN_CODE3 = 8'sd25;

  // Strap pin group
  typedef struct packed {
    logic [3:0] boost;
    logic [1:0] swing;
    logic       gainLo;
    logic       gainHi;
  } rdc_strap_t;

  // Settings applied to one analog channel
  typedef struct packed {
    logic [3:0]        boost;
    logic [1:0]        swing;
    logic [1:0]        gainCode;
    logic signed [7:0] gainTenthDb;
    logic              powerDown;
  } rdc_chan_cfg_t;

  // Flat gain code to gain in tenths of a dB
  function automatic logic signed [7:0] rdc_gain_decode(input logic [1:0] code);
    case (code)
      2'h0:    rdc_gain_decode = GAIN_CODE0;
      2'h1:    rdc_gain_decode = GAIN_CODE1;
      2'h2:    rdc_gain_decode = GAIN_CODE2;
      default: rdc_gain_decode = GAIN_CODE3;
    endcase
  endfunction : rdc_gain_decode

endpackage : rdc_pkg
